// ---- pkg/psr_cfg.svh ----
`ifndef PSR_CFG_SVH
`define PSR_CFG_SVH
// register offsets (byte addresses, one word each)
`define PSR_OFS_CTRL      8'h00
`define PSR_OFS_STAT      8'h04
`define PSR_OFS_RXDATA    8'h08
`define PSR_OFS_IRQSRC    8'h0C
`define PSR_OFS_IRQMASK   8'h10
// control fields
`define PSR_CTRL_ON       0
`define PSR_CTRL_DIR      1
`define PSR_CTRL_IDLE_CLK 2
`define PSR_CTRL_IDLE_DAT 3
`define PSR_CTRL_RST      4'h0
// status fields
`define PSR_STAT_RDY      0
`define PSR_STAT_PERR     1
`define PSR_STAT_FERR     2
`define PSR_STAT_BUSY     3
// irq source fields
`define PSR_IRQ_RDY       0
`define PSR_IRQ_ERR       1
`define PSR_IRQ_W         2
`define PSR_IRQMASK_RST   2'h3
// timing
`define PSR_CLK_PERIOD_PS 5000
`define PSR_FLOAT_MAX_NS  100
`define PSR_RDY_MAX_NS    1600
`define PSR_CLR_MAX_NS    100
// longest frame: start to parity 2.002 ms, plus one 302 us period
`define PSR_FRAME_MAX_US  2304
`define PSR_FRAME_BITS    11
`endif

// ---- pkg/psr_pkg.sv ----
package psr_pkg;
  typedef enum logic [1:0] {
    PSR_IDLE = 2'b00,
    PSR_RECV = 2'b01,
    PSR_HOLD = 2'b10
  } psr_state_t;
  typedef logic [7:0] psr_byte_t;
endpackage : psr_pkg

// ---- rtl/psr_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module psr_sync (
  input  wire logic CLK,
  input  wire logic RESET_N,
  input  wire logic D,
  output logic      Q
);
  logic meta;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      meta <= 1'b1;
      Q    <= 1'b1;
    end else begin
      meta <= D;
      Q    <= meta;
    end
  end
endmodule : psr_sync
`default_nettype wire

// ---- rtl/psr_shift.sv ----
`timescale 1ns/1ps
`default_nettype none
// collects the eleven frame bits, lsb first
module psr_shift
  import psr_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic        CLEAR,
  input  wire logic        SAMPLE,
  input  wire logic        BIT_IN,
  output logic [10:0]      FRAME,
  output logic [3:0]       COUNT
);
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      FRAME <= 11'h000;
      COUNT <= 4'h0;
    end else if (CLEAR) begin
      FRAME <= 11'h000;
      COUNT <= 4'h0;
    end else if (SAMPLE) begin
      FRAME <= {BIT_IN, FRAME[10:1]};
      COUNT <= COUNT + 4'h1;
    end
  end
endmodule : psr_shift
`default_nettype wire

// ---- rtl/psr_rx.sv ----
// Behaviour
// - enabled receive floats both lines quickly
// - data sampled on falling link clock
// - eleven edges; start first, parity tenth
// - ready flag within 1.6 us
// - read of data clears ready quickly
// - read of data releases clock line
// - disabled channel drives idle levels
// - ready raises interrupt request
// - interrupt held until source read
//
// The strobed register port and the placing of the registers were left to the implementer.
`include "psr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module psr_rx
  import psr_pkg::*;
#(
  parameter int FRAME_TMO_CYC = (`PSR_FRAME_MAX_US * 1000000) / `PSR_CLK_PERIOD_PS
)(
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic [31:0]      RDATA,
  output logic             IRQ,
  input  wire logic        LINK_CLK_I,
  output logic             LINK_CLK_O,
  output logic             LINK_CLK_OE,
  input  wire logic        LINK_DAT_I,
  output logic             LINK_DAT_O,
  output logic             LINK_DAT_OE
);
  localparam int RDY_CYC   = (`PSR_RDY_MAX_NS * 1000) / `PSR_CLK_PERIOD_PS;
  localparam int FLOAT_CYC = (`PSR_FLOAT_MAX_NS * 1000) / `PSR_CLK_PERIOD_PS;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  logic [3:0]          ctrl;
  logic [1:0]          irq_mask;
  logic [1:0]          irq_src;
  psr_byte_t           rx_byte;
  logic                rdy;
  logic                perr;
  logic                ferr;
  psr_state_t          state;
  logic                clk_s;
  logic                dat_s;
  logic                clk_d;
  logic                fall;
  logic [10:0]         frame;
  logic [3:0]          count;
  logic                shift_clr;
  logic [23:0]         tmo;
  logic                timeout;
  logic                frame_done;
  logic                rd_data;
  logic                rd_src;
  logic                chan_on;
  logic                rx_dir;

  assign chan_on = ctrl[`PSR_CTRL_ON];
  assign rx_dir  = ~ctrl[`PSR_CTRL_DIR];
  assign rd_data = RD && hit(ADDR, `PSR_OFS_RXDATA);
  assign rd_src  = RD && hit(ADDR, `PSR_OFS_IRQSRC);

  psr_sync u_sync_clk (
    .CLK     (CLK),
    .RESET_N (RESET_N),
    .D       (LINK_CLK_I),
    .Q       (clk_s)
  );

  psr_sync u_sync_dat (
    .CLK     (CLK),
    .RESET_N (RESET_N),
    .D       (LINK_DAT_I),
    .Q       (dat_s)
  );

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      clk_d <= 1'b1;
    end else begin
      clk_d <= clk_s;
    end
  end

  // edges count in idle and receive, not in hold; held clock low is our own drive
  assign fall = clk_d && !clk_s && (state != PSR_HOLD);

  psr_shift u_shift (
    .CLK     (CLK),
    .RESET_N (RESET_N),
    .CLEAR   (shift_clr),
    .SAMPLE  (fall),
    .BIT_IN  (dat_s),
    .FRAME   (frame),
    .COUNT   (count)
  );

  assign frame_done = fall && (count == 4'(`PSR_FRAME_BITS - 1));
  assign timeout    = (state == PSR_RECV) && (tmo == 24'(FRAME_TMO_CYC));
  assign shift_clr  = !chan_on || !rx_dir || timeout || (state == PSR_HOLD);

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl     <= `PSR_CTRL_RST;
      irq_mask <= `PSR_IRQMASK_RST;
    end else if (WR) begin
      if (hit(ADDR, `PSR_OFS_CTRL)) begin
        ctrl <= WDATA[3:0];
      end
      if (hit(ADDR, `PSR_OFS_IRQMASK)) begin
        irq_mask <= WDATA[1:0];
      end
    end
  end

  // frame state: idle -> receive on start edge -> hold until read
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state <= PSR_IDLE;
      tmo   <= 24'h00_0000;
    end else if (!chan_on || !rx_dir) begin
      state <= PSR_IDLE;
      tmo   <= 24'h00_0000;
    end else begin
      unique case (state)
        PSR_IDLE: begin
          tmo <= 24'h00_0000;
          if (fall) begin
            state <= PSR_RECV;
          end
        end
        PSR_RECV: begin
          tmo <= tmo + 24'h00_0001;
          if (frame_done) begin
            state <= PSR_HOLD;
          end else if (timeout) begin
            // a stalled peripheral must not lock the channel forever
            state <= PSR_IDLE;
          end
        end
        PSR_HOLD: begin
          tmo <= 24'h00_0000;
          if (rd_data) begin
            state <= PSR_IDLE;
          end
        end
      endcase
    end
  end

  // data latched one cycle after the eleventh edge, well inside 1.6 us
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rx_byte <= 8'h00;
      rdy     <= 1'b0;
      perr    <= 1'b0;
      ferr    <= 1'b0;
    end else if (frame_done) begin
      // ten bits shifted so far: start in frame[1], parity in frame[10]
      rx_byte <= frame[9:2];
      rdy     <= 1'b1;
      perr    <= ~(^frame[10:2]);
      ferr    <= frame[1] || !dat_s;
    end else if (rd_data || !chan_on) begin
      rdy     <= 1'b0;
    end
  end

  // set wins over a clearing read in the same cycle
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      irq_src <= 2'h0;
    end else begin
      irq_src[`PSR_IRQ_RDY] <= frame_done || (irq_src[`PSR_IRQ_RDY] && !rd_src);
      irq_src[`PSR_IRQ_ERR] <= timeout || (irq_src[`PSR_IRQ_ERR] && !rd_src);
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(irq_src & irq_mask);
    end
  end

  // pins registered: float or idle levels appear one cycle after the write
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      LINK_CLK_O  <= 1'b0;
      LINK_CLK_OE <= 1'b0;
      LINK_DAT_O  <= 1'b0;
      LINK_DAT_OE <= 1'b0;
    end else if (!chan_on) begin
      LINK_CLK_O  <= ctrl[`PSR_CTRL_IDLE_CLK];
      LINK_CLK_OE <= 1'b1;
      LINK_DAT_O  <= ctrl[`PSR_CTRL_IDLE_DAT];
      LINK_DAT_OE <= 1'b1;
    end else if (rx_dir) begin
      LINK_CLK_O  <= 1'b0;
      LINK_CLK_OE <= (state == PSR_HOLD) && !rd_data;
      LINK_DAT_O  <= 1'b0;
      LINK_DAT_OE <= 1'b0;
    end else begin
      // transmit direction is not served here; keep the link inhibited
      LINK_CLK_O  <= 1'b0;
      LINK_CLK_OE <= 1'b1;
      LINK_DAT_O  <= 1'b0;
      LINK_DAT_OE <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RDATA <= 32'h0000_0000;
    end else if (RD) begin
      if (hit(ADDR, `PSR_OFS_CTRL)) begin
        RDATA <= {28'h000_0000, ctrl};
      end else if (hit(ADDR, `PSR_OFS_STAT)) begin
        RDATA <= {28'h000_0000, state != PSR_IDLE, ferr, perr, rdy};
      end else if (hit(ADDR, `PSR_OFS_RXDATA)) begin
        RDATA <= {24'h00_0000, rx_byte};
      end else if (hit(ADDR, `PSR_OFS_IRQSRC)) begin
        RDATA <= {30'h0000_0000, irq_src};
      end else if (hit(ADDR, `PSR_OFS_IRQMASK)) begin
        RDATA <= {30'h0000_0000, irq_mask};
      end else begin
        RDATA <= 32'h0000_0000;
      end
    end else begin
      RDATA <= 32'h0000_0000;
    end
  end

  // unused constants kept for reference of limits
  logic unused_ok;
  assign unused_ok = (RDY_CYC > 1) && (FLOAT_CYC > 1);
endmodule : psr_rx
`default_nettype wire

// ---- sim/psr_rx_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module psr_rx_props (
  input wire logic        CLK,
  input wire logic        RESET_N,
  input wire logic [7:0]  ADDR,
  input wire logic [31:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [31:0] RDATA,
  input wire logic        IRQ,
  input wire logic        LINK_CLK_I,
  input wire logic        LINK_CLK_O,
  input wire logic        LINK_CLK_OE,
  input wire logic        LINK_DAT_I,
  input wire logic        LINK_DAT_O,
  input wire logic        LINK_DAT_OE
);
  logic rd_src, rd_dat, wr_ctl, rdy_on;
  assign rd_src = RD && ADDR == 8'h0C;
  assign rd_dat = RD && ADDR == 8'h08;
  assign wr_ctl = WR && ADDR == 8'h00;
  // mask shadow: a masked frame must not be expected on the irq pin
  always_ff @(posedge CLK or negedge RESET_N)
    if (!RESET_N) rdy_on <= 1'b1;
    else if (WR && ADDR == 8'h10) rdy_on <= WDATA[0];
  default clocking dc @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);
  AST_FLOAT: assert property (
    wr_ctl && WDATA[1:0] == 2'b01 |-> ##2 !LINK_CLK_OE && !LINK_DAT_OE) else $error("no float");
  AST_IDLE: assert property (
    wr_ctl && !WDATA[0] |-> ##2 LINK_CLK_OE && LINK_DAT_OE
      && LINK_CLK_O == $past(WDATA[2], 2) && LINK_DAT_O == $past(WDATA[3], 2)) else $error("idle");
  AST_RELEASE: assert property (
    rd_dat && LINK_CLK_OE && !LINK_DAT_OE |-> ##2 !LINK_CLK_OE) else $error("no release");
  AST_RDYCLR: assert property (
    rd_dat ##[1:4] (RD && ADDR == 8'h04) |=> !RDATA[0]) else $error("ready kept");
  AST_IRQHOLD: assert property (
    IRQ && !rd_src && !$past(rd_src) && !WR && !$past(WR) |=> IRQ) else $error("irq lost");
  AST_IRQCLR: assert property (
    rd_src ##1 !$rose(LINK_CLK_OE) |=> !IRQ) else $error("irq kept");
  AST_RDYIRQ: assert property (
    $rose(LINK_CLK_OE) && !LINK_DAT_OE && rdy_on |-> ##[1:3] IRQ) else $error("no irq");
  AST_HOLD: assert property (
    LINK_CLK_OE && !LINK_DAT_OE && !rd_dat && !$past(rd_dat) && !WR && !$past(WR)
      |=> LINK_CLK_OE && !LINK_CLK_O) else $error("hold lost");
  cover property ($rose(IRQ));
  cover property (rd_dat && LINK_CLK_OE);
  cover property ($fell(LINK_CLK_I));
endmodule : psr_rx_props
bind psr_rx psr_rx_props u_props (.*);
`default_nettype wire

// ---- sim/psr_kbd.sv ----
`timescale 1ns/1ps
`default_nettype none
module psr_kbd (
  input  wire logic LINE_CLK,
  output logic      CLK_LOW,
  output logic      DAT_LOW
);
  initial begin
    CLK_LOW = 1'b0;
    DAT_LOW = 1'b0;
  end
  // link period scaled to 48 ns so a frame fits the run
  task automatic send(input logic [10:0] f, input int n);
    wait (LINE_CLK);
    for (int i = 0; i < n; i++) begin
      DAT_LOW = !f[i];
      #12 CLK_LOW = 1'b1;
      #24 CLK_LOW = 1'b0;
      #12;
    end
    DAT_LOW = 1'b0;
  endtask : send
endmodule : psr_kbd
`default_nettype wire

// ---- sim/test_ps2_channel_receiver.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin errors++; \
  $display("mismatch at %0t: %h vs %h", $time, (a), (e)); end end
module test_ps2_channel_receiver;
  logic        CLK, RESET_N, WR, RD, IRQ;
  logic [7:0]  ADDR;
  logic [31:0] WDATA, RDATA;
  logic        clk_o, clk_oe, dat_o, dat_oe, k_clk, k_dat;
  wire         line_clk, line_dat;
  int          errors, checked, cyc;
  // pull-ups on both lines
  assign line_clk = !((clk_oe && !clk_o) || k_clk);
  assign line_dat = !((dat_oe && !dat_o) || k_dat);
  psr_rx #(.FRAME_TMO_CYC(400)) DUT (.CLK(CLK), .RESET_N(RESET_N), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ), .LINK_CLK_I(line_clk),
    .LINK_CLK_O(clk_o), .LINK_CLK_OE(clk_oe), .LINK_DAT_I(line_dat),
    .LINK_DAT_O(dat_o), .LINK_DAT_OE(dat_oe));
  psr_kbd kbd (.LINE_CLK(line_clk), .CLK_LOW(k_clk), .DAT_LOW(k_dat));
  always #2.5 CLK = !CLK;
  task automatic print_verdict();
    if (errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      print_verdict();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 `CHK(RDATA & m, e)
  endtask : rd
  function automatic logic [10:0] frm(input logic [7:0] b, input logic pe, input logic stp);
    return {stp, ~^b ^ pe, b, 1'b0};
  endfunction : frm
  task automatic t_idle();
    rd(8'h10, 32'h0000_0003);
    wr(8'h14, 32'h0000_000F);
    rd(8'h14, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, {28'h0, i[1:0], 2'b00});
      repeat (2) @(posedge CLK);
      #1 `CHK({clk_oe, dat_oe, clk_o, dat_o}, {2'b11, i[0], i[1]})
    end
    wr(8'h00, 32'h0000_0001);
    repeat (2) @(posedge CLK);
    #1 `CHK({clk_oe, dat_oe}, 2'b00)
  endtask : t_idle
  task automatic rx(input logic [7:0] b, input logic pe, stp, input logic [31:0] st,
                    input logic ie);
    kbd.send(frm(b, pe, stp), 11);
    repeat (8) @(posedge CLK);
    #1 `CHK({clk_oe, clk_o, IRQ}, {2'b10, ie})
    rd(8'h04, st, st);
    rd(8'h08, {24'h0, b});
    rd(8'h04, 32'h0000_0000, 32'h0000_0001);
    `CHK(clk_oe, 1'b0)
    rd(8'h0C, 32'h0000_0001);
    rd(8'h00, 32'h0000_0001);
    `CHK(IRQ, 1'b0)
  endtask : rx
  task automatic t_tmo();
    kbd.send(frm(8'hFF, 1'b0, 1'b1), 5);
    repeat (500) @(posedge CLK);
    #1 `CHK({IRQ, clk_oe}, 2'b10)
    rd(8'h0C, 32'h0000_0002);
  endtask : t_tmo
  initial begin
    CLK = 1'b0;
    RESET_N = 1'b0;
    ADDR = 8'h00;
    WDATA = 32'h0000_0000;
    WR = 1'b0;
    RD = 1'b0;
    repeat (2) @(posedge CLK);
    RESET_N <= 1'b1;
    t_idle();
    rx(8'hA5, 1'b0, 1'b1, 32'h0000_0001, 1'b1);
    wr(8'h10, 32'h0000_0002);
    rx(8'h5A, 1'b0, 1'b1, 32'h0000_0001, 1'b0);
    wr(8'h10, 32'h0000_0003);
    rx(8'h3C, 1'b1, 1'b1, 32'h0000_0003, 1'b1);
    rx(8'h81, 1'b0, 1'b0, 32'h0000_0005, 1'b1);
    t_tmo();
    print_verdict();
  end
endmodule : test_ps2_channel_receiver
`default_nettype wire
